// >>> logic/bml_boot_loader.sv
// boot mode selection and image loading sequencer
// How it works
// - straps sampled once after reset release
// - exactly four boot paths exist
// - low bits pick path, high bit flash family
// - flash cs strap low means no flash
// - flash straps inputs, then outputs for flash
// - flash image decrypted into ram before run
// - flash header read first gives image location
// - rom path starts rom firmware directly
// - network path waits for file transfer image
// - default server address 10.1.254.250
// - server address replaceable from flash parameter
// - rewrite flash only if good and present
// - transfer errors reported to remote client
// - first four bytes: destination in sram window
// - next four bytes: payload length
// - zero or oversize length: error, restart
// - trailer is inverted xor of words
// - checksum match jumps, mismatch restarts
// - errors shown on three led pins
// - error code values as listed
module bml_boot_loader
   import bml_pkg::*;
(
   input  wire logic        ref_clk_in,          // system clock, 200 MHz
   input  wire logic        srst_in,             // synchronous reset, high
   input  wire logic        boot_sel_bit0_in,    // strap pin, boot select bit 0
   input  wire logic        boot_sel_bit1_in,    // strap pin, boot select bit 1
   input  wire logic        boot_sel_bit2_in,    // strap pin, flash family
   input  wire logic        flash_clk_type0_strap_in, // strap, flash clock pin
   input  wire logic        flash_cs_type1_strap_in,  // strap, low = no flash
   input  wire logic        flash_clk_drv_in,    // flash engine serial clock
   input  wire logic        flash_cs_drv_in,     // flash engine chip select
   output logic             flash_clk_type0_strap_out, // pad output value
   output logic             flash_clk_type0_strap_oe_out, // pad drive enable
   output logic             flash_cs_type1_strap_out,  // pad output value
   output logic             flash_cs_type1_strap_oe_out,  // pad drive enable
   output logic             err_led_bit0_out,    // error code bit 0
   output logic             err_led_bit1_out,    // error code bit 1
   output logic             err_led_bit2_out,    // error code bit 2
   output logic             err_led_oe_out,      // led pins driven
   output logic [1:0]       boot_path_out,       // sampled boot path
   output logic             flash_family_out,    // sampled flash family
   output logic             flash_present_out,   // flash attached
   output logic             flash_req_out,       // flash engine request
   output logic             flash_hdr_out,       // request is header read
   output logic [31:0]      flash_img_addr_out,  // image location from header
   input  wire logic [31:0] flash_hdr_addr_in,   // header image location
   input  wire logic        flash_hdr_valid_in,  // header read done, pulse
   input  wire logic        flash_hdr_ok_in,     // header holds valid image
   input  wire logic [31:0] flash_ip_param_in,   // stored server address
   input  wire logic        flash_ip_param_valid_in, // stored address present
   input  wire logic        flash_load_done_in,  // decrypt copy done, pulse
   output logic [31:0]      tftp_server_ip_out,  // server address in use
   output logic             net_wait_out,        // awaiting network image
   input  wire logic        net_img_done_in,     // image received, pulse
   input  wire logic        net_img_ok_in,       // image passed integrity
   input  wire logic        net_xfer_err_in,     // session error, pulse
   output logic             net_err_report_out,  // send error to client, pulse
   output logic             net_prog_out,        // rewrite flash request
   input  wire logic        net_prog_done_in,    // flash rewrite done, pulse
   input  wire logic [7:0]  uart_rx_data_in,     // uart received byte
   input  wire logic        uart_rx_valid_in,    // byte strobe
   output logic             uart_err_msg_out,    // send error to host, pulse
   output logic             sram_we_out,         // sram word write strobe
   output logic [31:0]      sram_addr_out,       // sram word address
   output logic [31:0]      sram_wdata_out,      // sram word data
   output logic             run_out,             // start execution
   output logic             run_from_rom_out,    // execute rom firmware
   output logic [31:0]      run_addr_out         // jump address
);
   // strap synchronisers, two flops each
   logic [4:0] strap_s1;            // first stage, read by second only
   logic [4:0] strap_s2;            // second stage
   logic [4:0] strap_raw;           // pin bundle
   logic [3:0] strap_cnt;           // settle counter
   bml_state_e state;               // sequencer state
   bml_state_e next_state;          // next sequencer state
   logic [2:0]  err_code;           // latched error code
   logic [1:0]  byte_idx;           // byte within current word
   logic [31:0] word_sr;            // assembly shift register
   logic [31:0] dest;               // uart destination
   logic [31:0] len;                // uart remaining length
   logic [31:0] wr_ptr;             // uart write address
   logic [31:0] xsum;               // running xor of words
   logic        fl_present;         // flash present strap

   assign strap_raw = {flash_cs_type1_strap_in, flash_clk_type0_strap_in,
                       boot_sel_bit2_in, boot_sel_bit1_in, boot_sel_bit0_in};

   // word assembly, least significant byte first
   wire        word_done = uart_rx_valid_in && (byte_idx == LAST_BYTE);
   wire [31:0] word_full = {uart_rx_data_in, word_sr[31:8]};
   // header and trailer checks
   wire addr_bad = (word_full < SRAM_LO) || (word_full > SRAM_HI);
   wire len_bad  = (word_full == 32'h0) || (word_full > LEN_MAX);
   wire sum_ok   = (word_full == ~xsum);
   wire [31:0] len_left = len - 32'h4;
   wire        in_boot  = (state == ST_STRAP) || (state == ST_DECIDE);

   // strap synchroniser
   always_ff @(posedge ref_clk_in) begin
      strap_s1 <= strap_raw;
      strap_s2 <= strap_s1;
   end

   // next state decode
   always_comb begin
      next_state = state;
      case (state)
         ST_STRAP:    if (strap_cnt == STRAP_WAIT) next_state = ST_DECIDE;
         ST_DECIDE: begin
            // four paths only
            case (boot_path_out)
               BP_FLASH: next_state = fl_present ? ST_FL_HDR : ST_FAIL;
               BP_NET:   next_state = ST_NET_WAIT;
               BP_ROM:   next_state = ST_RUN;
               BP_UART:  next_state = ST_U_ADDR;
               default:  next_state = ST_FAIL;
            endcase
         end
         ST_FL_HDR: if (flash_hdr_valid_in)
            next_state = flash_hdr_ok_in ? ST_FL_LOAD : ST_FAIL;
         ST_FL_LOAD:  if (flash_load_done_in) next_state = ST_RUN;
         ST_NET_WAIT: if (net_img_done_in && net_img_ok_in && fl_present)
            next_state = ST_NET_PROG;
         ST_NET_PROG: if (net_prog_done_in) next_state = ST_FL_HDR;
         ST_U_ADDR:   if (word_done) next_state = addr_bad ? ST_U_ADDR : ST_U_LEN;
         ST_U_LEN:    if (word_done) next_state = len_bad ? ST_U_ADDR : ST_U_DATA;
         ST_U_DATA:   if (word_done && len_left == 32'h0) next_state = ST_U_SUM;
         ST_U_SUM:    if (word_done) next_state = sum_ok ? ST_RUN : ST_U_ADDR;
         ST_RUN:      next_state = ST_RUN;
         ST_FAIL:     next_state = ST_FAIL;
         default:     next_state = ST_FAIL;
      endcase
   end

   // state, strap capture and counters
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         state         <= ST_STRAP;
         strap_cnt     <= 4'h0;
         boot_path_out <= BP_UART;
         flash_family_out <= 1'b0;
         fl_present    <= 1'b0;
      end else begin
         state <= next_state;
         if (state == ST_STRAP) begin
            strap_cnt <= strap_cnt + 4'h1;
            if (strap_cnt == STRAP_WAIT) begin
               boot_path_out    <= strap_s2[1:0];
               flash_family_out <= strap_s2[2];
               fl_present       <= strap_s2[4];
            end
         end
      end
   end

   // uart byte collection and image write
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         byte_idx <= 2'h0;
         word_sr  <= 32'h0;
         dest     <= 32'h0;
         len      <= 32'h0;
         wr_ptr   <= 32'h0;
         xsum     <= 32'h0;
         sram_we_out    <= 1'b0;
         sram_addr_out  <= 32'h0;
         sram_wdata_out <= 32'h0;
         uart_err_msg_out <= 1'b0;
      end else begin
         sram_we_out      <= 1'b0;
         uart_err_msg_out <= 1'b0;
         if (uart_rx_valid_in) begin
            byte_idx <= byte_idx + 2'h1;
            word_sr  <= word_full;
         end
         if (word_done) begin
            case (state)
               ST_U_ADDR: begin
                  dest   <= word_full;
                  wr_ptr <= word_full;
                  xsum   <= 32'h0;
                  uart_err_msg_out <= addr_bad;
               end
               ST_U_LEN: begin
                  len <= word_full;
                  uart_err_msg_out <= len_bad;
               end
               ST_U_DATA: begin
                  sram_we_out    <= 1'b1;
                  sram_addr_out  <= wr_ptr;
                  sram_wdata_out <= word_full;
                  wr_ptr <= wr_ptr + 32'h4;
                  len    <= len_left;
                  xsum   <= xsum ^ word_full;
               end
               ST_U_SUM:  uart_err_msg_out <= !sum_ok;
               default:   xsum <= xsum;
            endcase
         end
      end
   end

   // error code, run and network outputs
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         err_code <= ERR_NONE;
         tftp_server_ip_out <= TFTP_IP_DEFAULT;
         net_err_report_out <= 1'b0;
         run_addr_out <= 32'h0;
      end else begin
         net_err_report_out <= (state == ST_NET_WAIT) &&
                               (net_xfer_err_in || (net_img_done_in && !net_img_ok_in));
         if (state == ST_NET_WAIT && flash_ip_param_valid_in)
            tftp_server_ip_out <= flash_ip_param_in;
         if (state == ST_DECIDE && boot_path_out == BP_FLASH && !fl_present)
            err_code <= ERR_NO_FLASH;
         if (state == ST_NET_WAIT && net_img_done_in && net_img_ok_in && !fl_present)
            err_code <= ERR_NO_FLASH;
         if (state == ST_FL_HDR && flash_hdr_valid_in && !flash_hdr_ok_in)
            err_code <= ERR_BAD_IMG;
         if (word_done) begin
            if (state == ST_U_ADDR)
               err_code <= addr_bad ? ERR_BAD_ADDR : ERR_NONE;
            if (state == ST_U_LEN && len_bad)
               err_code <= ERR_TOO_BIG;
            if (state == ST_U_SUM && !sum_ok)
               err_code <= ERR_CHECKSUM;
            if (state == ST_U_SUM && sum_ok)
               run_addr_out <= dest;
         end
         if (state == ST_FL_LOAD && flash_load_done_in)
            run_addr_out <= flash_img_addr_out;
      end
   end

   // flash image location from header
   always_ff @(posedge ref_clk_in) begin
      if (srst_in)
         flash_img_addr_out <= 32'h0;
      else if (state == ST_FL_HDR && flash_hdr_valid_in)
         flash_img_addr_out <= flash_hdr_addr_in;
   end

   // pad direction: straps are inputs while booting, flash lines later only when flash is present
   assign flash_clk_type0_strap_oe_out = !in_boot && fl_present;
   assign flash_cs_type1_strap_oe_out  = !in_boot && fl_present;
   assign flash_clk_type0_strap_out    = flash_clk_drv_in;
   assign flash_cs_type1_strap_out     = flash_cs_drv_in;
   // led pins show the error code once boot sampling is over
   assign err_led_oe_out   = !in_boot;
   assign err_led_bit0_out = err_code[0];
   assign err_led_bit1_out = err_code[1];
   assign err_led_bit2_out = err_code[2];
   assign flash_present_out = fl_present;
   assign flash_req_out    = (state == ST_FL_HDR) || (state == ST_FL_LOAD);
   assign flash_hdr_out    = (state == ST_FL_HDR);
   assign net_wait_out     = (state == ST_NET_WAIT);
   assign net_prog_out     = (state == ST_NET_PROG);
   assign run_out          = (state == ST_RUN);
   assign run_from_rom_out = (state == ST_RUN) && (boot_path_out == BP_ROM);

   // checks, all on the system clock and quiet in reset
   default clocking bml_chk_cb @(posedge ref_clk_in);
   endclocking
   default disable iff (srst_in);
   // single-cycle conditions shared by the checks
   sequence data_word_s;
      state == ST_U_DATA && word_done;
   endsequence
   sequence sram_write_s;
      sram_we_out && sram_addr_out == $past(wr_ptr);
   endsequence
   sequence hdr_good_s;
      state == ST_FL_HDR && flash_hdr_valid_in && flash_hdr_ok_in;
   endsequence
   sequence sum_bad_s;
      state == ST_U_SUM && word_done && !sum_ok;
   endsequence
   // boot decision, uart path and run hold
   rom_direct_a: assert property (state == ST_DECIDE && boot_path_out == BP_ROM
      |=> run_out && run_from_rom_out)
      else $error("rom path did not start");
   no_flash_a: assert property (state == ST_DECIDE && boot_path_out == BP_FLASH
      && !fl_present |=> err_code == ERR_NO_FLASH)
      else $error("no flash code missing");
   len_err_a: assert property (state == ST_U_LEN && word_done && len_bad
      |=> uart_err_msg_out && state == ST_U_ADDR)
      else $error("bad length not refused");
   addr_err_a: assert property (state == ST_U_ADDR && word_done && addr_bad
      |=> err_code == ERR_BAD_ADDR)
      else $error("bad address not flagged");
   sum_ok_a: assert property (state == ST_U_SUM && word_done && sum_ok
      |=> run_out && run_addr_out == dest)
      else $error("good image not launched");
   sum_bad_a: assert property (sum_bad_s
      |=> err_code == ERR_CHECKSUM)
      else $error("checksum error not flagged");
   sum_restart_a: assert property (sum_bad_s
      |=> uart_err_msg_out && state == ST_U_ADDR)
      else $error("bad checksum did not restart");
   data_write_a: assert property (data_word_s
      |=> sram_write_s)
      else $error("data word not written");
   len_code_a: assert property (state == ST_U_LEN && word_done && len_bad
      |=> err_code == ERR_TOO_BIG)
      else $error("length code missing");
   uart_start_a: assert property (state == ST_DECIDE && boot_path_out == BP_UART
      |=> state == ST_U_ADDR)
      else $error("uart path not entered");
   run_hold_a: assert property (run_out
      |=> run_out)
      else $error("execution start dropped");
   // flash and network paths
   hdr_load_a: assert property (hdr_good_s
      |=> flash_req_out && !flash_hdr_out)
      else $error("header not followed by load");
   load_run_a: assert property (state == ST_FL_LOAD && flash_load_done_in
      |=> run_out && !run_from_rom_out)
      else $error("loaded image not started");
   net_prog_a: assert property (net_prog_out
      |-> fl_present && $past(state) inside {ST_NET_WAIT, ST_NET_PROG})
      else $error("flash rewrite without cause");
   net_report_a: assert property (net_wait_out && net_xfer_err_in
      |=> net_err_report_out)
      else $error("session error not reported");
   net_no_flash_a: assert property (
      net_wait_out && net_img_done_in && net_img_ok_in && !fl_present
      |=> !net_prog_out && err_code == ERR_NO_FLASH)
      else $error("rewrite without flash");
   // pins
   pad_dir_a: assert property (in_boot
      |-> !flash_clk_type0_strap_oe_out && !flash_cs_type1_strap_oe_out)
      else $error("flash pads driven in boot");
   led_code_a: assert property (err_led_oe_out
      |-> {err_led_bit2_out, err_led_bit1_out, err_led_bit0_out} == err_code)
      else $error("led code mismatch");
   path_hold_a: assert property (!in_boot
      |=> $stable(boot_path_out) && $stable(fl_present))
      else $error("boot path changed");
endmodule

// >>> logic/bml_pkg.sv
// package of constants for the boot mode image loader
package bml_pkg;
   // boot path codes on the two low boot-select bits
   localparam logic [1:0] BP_UART  = 2'h0;
   localparam logic [1:0] BP_NET   = 2'h1;
   localparam logic [1:0] BP_FLASH = 2'h2;
   localparam logic [1:0] BP_ROM   = 2'h3;
   // boot error codes driven on the led pins, except ERR_BAD_MODE which is never set
   localparam logic [2:0] ERR_NONE     = 3'h0;
   localparam logic [2:0] ERR_BAD_IMG  = 3'h1;
   localparam logic [2:0] ERR_TOO_BIG  = 3'h2;
   localparam logic [2:0] ERR_BAD_ADDR = 3'h3;
   localparam logic [2:0] ERR_CHECKSUM = 3'h4;
   localparam logic [2:0] ERR_NO_FLASH = 3'h5;
   localparam logic [2:0] ERR_BAD_MODE = 3'h6;
   // uart download limits
   localparam logic [31:0] SRAM_LO   = 32'h0202_0000;
   localparam logic [31:0] SRAM_HI   = 32'h0203_ffff;
   localparam logic [31:0] LEN_MAX   = 32'h0002_0000;
   localparam logic [1:0]  LAST_BYTE = 2'h3;
   // default file-transfer server address 10.1.254.250
   localparam logic [31:0] TFTP_IP_DEFAULT = 32'h0a01_fefa;
   // strap settle delay, in cycles after reset release
   localparam logic [3:0]  STRAP_WAIT = 4'h4;
   // boot sequencer states
   typedef enum logic [3:0] {
      ST_STRAP, ST_DECIDE, ST_FL_HDR, ST_FL_LOAD, ST_NET_WAIT, ST_NET_PROG,
      ST_U_ADDR, ST_U_LEN, ST_U_DATA, ST_U_SUM, ST_RUN, ST_FAIL
   } bml_state_e;
endpackage

// >>> testbench/bml_flash_partner.sv
// flash engine model answering header, load and rewrite requests
module bml_flash_partner (
   input  wire logic        clk_in,        // system clock
   input  wire logic        req_in,        // flash request level
   input  wire logic        hdr_in,        // request is a header read
   input  wire logic        prog_in,       // flash rewrite request
   input  wire logic        good_in,       // header holds a valid image
   input  wire logic [3:0]  delay_in,      // answer delay in cycles
   output logic             hdr_valid_out, // header read done pulse
   output logic             hdr_ok_out,    // header verdict
   output logic [31:0]      hdr_addr_out,  // image location
   output logic             load_done_out, // decrypt copy done pulse
   output logic             prog_done_out, // rewrite done pulse
   output logic             sclk_out,      // serial clock, still outside requests
   output logic             cs_out         // chip select, low while busy
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] IMG_LOC = 32'h0000_0100; // image location in flash
   // serial clock runs only while a request stands
   initial begin
      sclk_out = 1'b0;
      cs_out = 1'b1;
      forever begin
         @(negedge clk_in);
         sclk_out = req_in ? ~sclk_out : 1'b0;
         cs_out = ~(req_in | prog_in);
      end
   end
   // answer each request after the chosen delay; idle bus shows inverse data
   initial begin
      {hdr_valid_out, load_done_out, prog_done_out} = 3'h0;
      hdr_ok_out = 1'b0;
      hdr_addr_out = ~IMG_LOC;
      forever begin
         @(negedge clk_in);
         if (req_in | prog_in) begin
            repeat (delay_in) @(negedge clk_in);
            hdr_addr_out = IMG_LOC;
            hdr_ok_out = good_in;
            if (prog_in) prog_done_out = 1'b1;
            else if (hdr_in) hdr_valid_out = 1'b1;
            else load_done_out = 1'b1;
            @(negedge clk_in);
            {hdr_valid_out, load_done_out, prog_done_out} = 3'h0;
            hdr_ok_out = ~good_in;
            hdr_addr_out = ~IMG_LOC;
            repeat (2) @(negedge clk_in);
         end
      end
   end
endmodule

// >>> testbench/bml_boot_loader_bench.sv
// self-checking bench for the boot mode loader with a reference queue model
module bml_boot_loader_bench;
   import bml_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int WATCH_NS = 100000; // far above the expected run length
   logic ref_clk_in, srst_in, boot_sel_bit0_in, boot_sel_bit1_in, boot_sel_bit2_in;
   logic flash_clk_type0_strap_in, flash_cs_type1_strap_in, flash_clk_drv_in, flash_cs_drv_in;
   logic flash_clk_type0_strap_out, flash_clk_type0_strap_oe_out, flash_cs_type1_strap_out;
   logic flash_cs_type1_strap_oe_out, err_led_bit0_out, err_led_bit1_out, err_led_bit2_out;
   logic err_led_oe_out, flash_family_out, flash_present_out, flash_req_out, flash_hdr_out;
   logic flash_hdr_valid_in, flash_hdr_ok_in, flash_ip_param_valid_in, flash_load_done_in;
   logic net_wait_out, net_img_done_in, net_img_ok_in, net_xfer_err_in, net_err_report_out;
   logic net_prog_out, net_prog_done_in, uart_rx_valid_in, uart_err_msg_out, sram_we_out;
   logic run_out, run_from_rom_out, good, cs_pull;
   logic [1:0]  boot_path_out;                 // sampled path
   logic [2:0]  sel, leds;                     // strap pulls and led code
   logic [3:0]  fl_delay;                      // partner answer delay
   logic [7:0]  uart_rx_data_in;               // uart byte
   logic [31:0] flash_img_addr_out, flash_hdr_addr_in, flash_ip_param_in, tftp_server_ip_out;
   logic [31:0] sram_addr_out, sram_wdata_out, run_addr_out, seed;
   logic [31:0] exp_addr[$], exp_data[$];      // expected sram writes
   int          bad_count, n_tests, err_cnt, err_seen, rep_cnt;
   // shared pins: driven value when enabled, else the pull resistor
   assign boot_sel_bit0_in = err_led_oe_out === 1'b1 ? err_led_bit0_out : sel[0];
   assign boot_sel_bit1_in = err_led_oe_out === 1'b1 ? err_led_bit1_out : sel[1];
   assign boot_sel_bit2_in = err_led_oe_out === 1'b1 ? err_led_bit2_out : sel[2];
   assign flash_clk_type0_strap_in = flash_clk_type0_strap_oe_out === 1'b1 ?
                                     flash_clk_type0_strap_out : 1'b1;
   assign flash_cs_type1_strap_in = flash_cs_type1_strap_oe_out === 1'b1 ?
                                    flash_cs_type1_strap_out : cs_pull;
   assign leds = {err_led_bit2_out, err_led_bit1_out, err_led_bit0_out};
   bml_boot_loader dut (.*);
   bml_flash_partner flash (.clk_in(ref_clk_in), .req_in(flash_req_out), .hdr_in(flash_hdr_out),
      .prog_in(net_prog_out), .good_in(good), .delay_in(fl_delay),
      .hdr_valid_out(flash_hdr_valid_in), .hdr_ok_out(flash_hdr_ok_in),
      .hdr_addr_out(flash_hdr_addr_in), .load_done_out(flash_load_done_in),
      .prog_done_out(net_prog_done_in), .sclk_out(flash_clk_drv_in), .cs_out(flash_cs_drv_in));
   // clock, 5 ns period
   always #2.5 ref_clk_in = ~ref_clk_in;
   // compare one value and count
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // print counts and verdict, end the run
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // pulse counters and sram write comparison against the queue model
   always @(posedge ref_clk_in) begin
      if (uart_err_msg_out === 1'b1) err_cnt++;
      if (net_err_report_out === 1'b1) rep_cnt++;
      if (sram_we_out === 1'b1) begin
         if (exp_addr.size() == 0) check("sram_extra", 32'h1, 32'h0);
         else begin
            check("sram_addr", sram_addr_out, exp_addr.pop_front());
            check("sram_data", sram_wdata_out, exp_data.pop_front());
         end
      end
   end
   // reset with new straps, then check what was sampled
   task automatic boot(input logic [1:0] path, input logic fam, input logic fl);
      @(negedge ref_clk_in);
      srst_in = 1'b1;
      sel = {fam, path};
      cs_pull = fl;
      fl_delay = 4'($random(seed));
      repeat (2) @(negedge ref_clk_in);
      check("oe_in_boot", {30'h0, flash_cs_type1_strap_oe_out, err_led_oe_out}, 32'h0);
      srst_in = 1'b0;
      repeat (12) @(negedge ref_clk_in);
      check("path", {29'h0, flash_family_out, boot_path_out}, {29'h0, fam, path});
      check("flash_present", {31'h0, flash_present_out}, {31'h0, fl});
      err_seen = err_cnt;
   endtask
   // one uart word, least significant byte first
   task automatic send_word(input logic [31:0] w);
      for (int i = 0; i < 4; i++) begin
         @(negedge ref_clk_in);
         uart_rx_data_in = w[8*i +: 8];
         uart_rx_valid_in = 1'b1;
      end
      @(negedge ref_clk_in);
      uart_rx_valid_in = 1'b0;
   endtask
   // header, random payload and checksum trailer
   task automatic load(input logic [31:0] dest, input int nw, input bit ok);
      logic [31:0] w, x;
      x = 32'h0;
      send_word(dest);
      send_word(32'(nw * 4));
      for (int k = 0; k < nw; k++) begin
         w = $random(seed);
         x = x ^ w;
         exp_addr.push_back(dest + 32'(4 * k));
         exp_data.push_back(w);
         send_word(w);
      end
      send_word(ok ? ~x : x);
   endtask
   // one error pulse to the host and the led code
   task automatic expect_err(input logic [2:0] code);
      repeat (3) @(negedge ref_clk_in);
      check("uart_err_pulses", 32'(err_cnt), 32'(err_seen + 1));
      err_seen = err_cnt;
      check("led_code", {29'h0, leds}, {29'h0, code});
   endtask
   // bounded wait for execution start
   task automatic wait_run;
      for (int i = 0; i < 300 && run_out !== 1'b1; i++) @(negedge ref_clk_in);
      check("run_started", {31'h0, run_out}, 32'h1);
   endtask
   // one network client event
   task automatic net_pulse(input bit err, input bit ok);
      @(negedge ref_clk_in);
      net_xfer_err_in = err;
      net_img_done_in = ~err;
      net_img_ok_in = ok;
      @(negedge ref_clk_in);
      net_xfer_err_in = 1'b0;
      net_img_done_in = 1'b0;
      net_img_ok_in = ~ok;
      repeat (3) @(negedge ref_clk_in);
   endtask
   // watchdog
   initial begin
      #WATCH_NS;
      bad_count++;
      print_verdict;
   end
   // main sequence
   initial begin
      seed = 32'h44b8e704;
      {ref_clk_in, srst_in, sel, cs_pull, good, fl_delay} = {1'b0, 1'b1, 3'h0, 1'b1, 1'b1, 4'h0};
      {uart_rx_data_in, uart_rx_valid_in, net_img_done_in, net_img_ok_in} = 11'h0;
      {net_xfer_err_in, flash_ip_param_valid_in, flash_ip_param_in} = 34'h0;
      {bad_count, n_tests, err_cnt, err_seen, rep_cnt} = '0;
      boot(BP_UART, 1'b0, 1'b1);
      send_word(SRAM_HI + 32'h1);
      expect_err(ERR_BAD_ADDR);
      send_word(SRAM_LO - 32'h4);
      expect_err(ERR_BAD_ADDR);
      send_word(SRAM_HI - 32'h7);
      send_word(32'h0);
      expect_err(ERR_TOO_BIG);
      send_word(SRAM_LO);
      send_word(LEN_MAX + 32'h4);
      expect_err(ERR_TOO_BIG);
      load(SRAM_HI - 32'h7, 2, 1'b0);
      expect_err(ERR_CHECKSUM);
      load(SRAM_LO, 5, 1'b1);
      wait_run;
      check("run_addr", run_addr_out, SRAM_LO);
      check("writes_left", 32'(exp_addr.size()), 32'h0);
      boot(BP_ROM, 1'b1, 1'b1);
      sel = ~sel;
      wait_run;
      check("rom_run", {31'h0, run_from_rom_out}, 32'h1);
      check("path_kept", {30'h0, boot_path_out}, {30'h0, BP_ROM});
      check("no_error", {29'h0, leds}, {29'h0, ERR_NONE});
      boot(BP_FLASH, 1'b0, 1'b0);
      check("no_flash", {29'h0, leds}, {29'h0, ERR_NO_FLASH});
      good = 1'b0;
      boot(BP_FLASH, 1'b1, 1'b1);
      repeat (25) @(negedge ref_clk_in);
      check("bad_image", {29'h0, leds, run_out}, {28'h0, ERR_BAD_IMG, 1'b0});
      good = 1'b1;
      boot(BP_FLASH, 1'b0, 1'b1);
      for (int i = 0; i < 20 && flash_req_out !== 1'b1; i++) @(negedge ref_clk_in);
      check("flash_pads", {28'h0, flash_clk_type0_strap_oe_out, flash_cs_type1_strap_oe_out,
            flash_clk_type0_strap_out, flash_cs_type1_strap_out},
            {28'h0, 2'h3, flash_clk_drv_in, flash_cs_drv_in});
      wait_run;
      check("flash_img", flash_img_addr_out, 32'h0000_0100);
      check("flash_run_addr", run_addr_out, 32'h0000_0100);
      check("flash_ram_run", {31'h0, run_from_rom_out}, 32'h0);
      boot(BP_NET, 1'b0, 1'b1);
      check("ip_default", tftp_server_ip_out, TFTP_IP_DEFAULT);
      check("net_wait", {31'h0, net_wait_out}, 32'h1);
      net_pulse(1'b1, 1'b0);
      check("err_report", 32'(rep_cnt), 32'h1);
      net_pulse(1'b0, 1'b0);
      check("no_rewrite", {31'h0, net_prog_out}, 32'h0);
      check("err_report_2", 32'(rep_cnt), 32'h2);
      net_pulse(1'b0, 1'b1);
      wait_run;
      flash_ip_param_valid_in = 1'b1;
      flash_ip_param_in = $random(seed);
      boot(BP_NET, 1'b0, 1'b1);
      check("ip_param", tftp_server_ip_out, flash_ip_param_in);
      boot(BP_NET, 1'b0, 1'b0);
      net_pulse(1'b0, 1'b1);
      check("net_no_flash", {29'h0, leds, net_prog_out}, {28'h0, ERR_NO_FLASH, 1'b0});
      print_verdict;
   end
endmodule
